/* File: rtl/fesc_params.svh */
// Constants for the erase-suspend command sequencer
// Operation
// - Nested word program busy: B0H suspends it, other codes keep it busy.
// - Nested word program suspended: D0H resumes it, other codes keep it suspended.
// - Nested buffered confirm: D0H starts programming, other codes abort with error.
// - Nested buffered busy: B0H suspends it, other codes keep it running.
// - Factory setup: D0H enters loading of 32 words, else ready with error.
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH
`define FESC_CMD_RESUME   8'hD0
`define FESC_CMD_SUSPEND  8'hB0
`define FESC_CMD_WPROG_A  8'h10
`define FESC_CMD_WPROG_B  8'h40
`define FESC_CMD_BUFPROG  8'hE8
`define FESC_CMD_FACTORY  8'h80
`define FESC_CMD_LOCKSET  8'h60
`define FESC_FACTORY_WORDS 32
`endif

/* File: rtl/fesc_pkg.sv */
// Types for the erase-suspend command sequencer
package fesc_pkg;
  typedef enum logic [3:0] {
    FESC_READY,
    FESC_ERASE_SUSP,
    FESC_WP_SETUP,
    FESC_WP_BUSY,
    FESC_WP_SUSP,
    FESC_BP_SETUP,
    FESC_BP_LOAD,
    FESC_BP_CONFIRM,
    FESC_BP_BUSY,
    FESC_BP_SUSP,
    FESC_LOCK_SETUP,
    FESC_FX_SETUP,
    FESC_FX_LOAD,
    FESC_FX_BUSY
  } fesc_state_t;
endpackage : fesc_pkg

/* File: rtl/fesc_cmd_if.sv */
// Interface carrying a decoded command write
`timescale 1ns/1ps
interface fesc_cmd_if;
  logic       wr;
  logic [7:0] code;
  logic       is_resume;
  logic       is_suspend;
  modport src (output wr, output code, input is_resume, input is_suspend);
  modport dec (input wr, input code, output is_resume, output is_suspend);
endinterface : fesc_cmd_if

/* File: rtl/fesc_cmd_decode.sv */
// Command code decoder
`timescale 1ns/1ps
`include "fesc_params.svh"
module fesc_cmd_decode
  import fesc_pkg::*;
(
  fesc_cmd_if.dec cmd
);
  assign cmd.is_resume  = cmd.wr && (cmd.code == `FESC_CMD_RESUME);
  assign cmd.is_suspend = cmd.wr && (cmd.code == `FESC_CMD_SUSPEND);
endmodule : fesc_cmd_decode

/* File: rtl/fesc_seq.sv */
// Erase-suspend nested command sequencer top
`timescale 1ns/1ps
`include "fesc_params.svh"
module fesc_seq
  import fesc_pkg::*;
#(
  parameter int FX_WORDS = `FESC_FACTORY_WORDS,
  parameter int BP_WORDS = 32,
  parameter int BA_W     = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              cmd_wr,
  input  wire logic [15:0]       cmd_data,
  input  wire logic [BA_W-1:0]   cmd_block,
  input  wire logic              enter_erase_susp,
  input  wire logic              enter_factory,
  input  wire logic              op_done,
  output logic [3:0]             state_code,
  output logic                   prog_error,
  output logic                   lock_error,
  output logic                   unlock_pulse,
  output logic                   data_wr,
  output logic [15:0]            data_word
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  fesc_cmd_if cmd ();
  assign cmd.wr   = cmd_wr;
  assign cmd.code = cmd_data[7:0];
  fesc_cmd_decode u_dec (.cmd(cmd));

  fesc_state_t     state;
  fesc_state_t     next_state;
  logic [5:0]      cnt;
  logic [BA_W-1:0] fx_block;
  logic            next_perr;
  logic            next_lerr;
  logic            next_unlock;
  logic            next_dwr;

  // ----------------------------------------------------------------
  // Command selection
  // ----------------------------------------------------------------
  wire logic is_wprog   = cmd.wr && (cmd.code == `FESC_CMD_WPROG_A || cmd.code == `FESC_CMD_WPROG_B);
  wire logic is_bufprog = cmd.wr && (cmd.code == `FESC_CMD_BUFPROG);
  wire logic is_lockset = cmd.wr && (cmd.code == `FESC_CMD_LOCKSET);
  wire logic blk_match  = (cmd_block == fx_block);
  wire logic bp_last    = (cnt == 6'(BP_WORDS - 1));
  wire logic fx_last    = (cnt == 6'(FX_WORDS - 1));
  wire logic fx_capture = (state == FESC_FX_SETUP) && cmd.wr;
  wire logic state_move = (next_state != state);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_perr   = 1'b0;
    next_lerr   = 1'b0;
    next_unlock = 1'b0;
    next_dwr    = 1'b0;
    unique case (state)
      FESC_READY: begin
        if (enter_erase_susp) begin
          next_state = FESC_ERASE_SUSP;
        end else if (enter_factory) begin
          next_state = FESC_FX_SETUP;
        end
      end
      FESC_ERASE_SUSP: begin
        if (is_wprog) begin
          next_state = FESC_WP_SETUP;
        end else if (is_bufprog) begin
          next_state = FESC_BP_SETUP;
        end else if (is_lockset) begin
          next_state = FESC_LOCK_SETUP;
        end else if (cmd.is_resume) begin
          next_state = FESC_READY;
        end
      end
      FESC_WP_SETUP: begin
        if (cmd.wr) begin
          next_state = FESC_WP_BUSY;
          next_dwr   = 1'b1;
        end
      end
      FESC_WP_BUSY: begin
        if (cmd.is_suspend) begin
          next_state = FESC_WP_SUSP;
        end else if (op_done) begin
          next_state = FESC_ERASE_SUSP;
        end
      end
      FESC_WP_SUSP: begin
        if (cmd.is_resume) begin
          next_state = FESC_WP_BUSY;
        end
      end
      FESC_BP_SETUP: begin
        if (cmd.wr) begin
          next_state = FESC_BP_LOAD;
        end
      end
      FESC_BP_LOAD: begin
        if (cmd.wr) begin
          next_dwr = 1'b1;
          if (bp_last) begin
            next_state = FESC_BP_CONFIRM;
          end
        end
      end
      FESC_BP_CONFIRM: begin
        if (cmd.is_resume) begin
          next_state = FESC_BP_BUSY;
        end else if (cmd.wr) begin
          next_state = FESC_ERASE_SUSP;
          next_perr  = 1'b1;
        end
      end
      FESC_BP_BUSY: begin
        if (cmd.is_suspend) begin
          next_state = FESC_BP_SUSP;
        end else if (op_done) begin
          next_state = FESC_ERASE_SUSP;
        end
      end
      FESC_BP_SUSP: begin
        if (cmd.is_resume) begin
          next_state = FESC_BP_BUSY;
        end
      end
      FESC_LOCK_SETUP: begin
        if (cmd.wr) begin
          next_state  = FESC_ERASE_SUSP;
          next_unlock = cmd.is_resume;
          next_lerr   = !cmd.is_resume;
        end
      end
      FESC_FX_SETUP: begin
        if (cmd.is_resume) begin
          next_state = FESC_FX_LOAD;
        end else if (cmd.wr) begin
          next_state = FESC_READY;
          next_perr  = 1'b1;
        end
      end
      FESC_FX_LOAD: begin
        if (cmd.wr) begin
          next_dwr = 1'b1;
          if (fx_last) begin
            next_state = FESC_FX_BUSY;
          end
        end
      end
      FESC_FX_BUSY: begin
        if (cmd.wr && blk_match) begin
          next_dwr = 1'b1;
        end else if (cmd.wr || op_done) begin
          next_state = FESC_READY;
        end
      end
      default: begin
        next_state = FESC_READY;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Word count
  // ----------------------------------------------------------------
  wire logic [5:0] next_cnt = state_move ? 6'h00 : (next_dwr ? cnt + 6'h01 : cnt);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= FESC_READY;
      state_code <= 4'h0;
    end else begin
      state      <= next_state;
      state_code <= 4'(next_state);
    end
  end

  // ----------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_error   <= 1'b0;
      lock_error   <= 1'b0;
      unlock_pulse <= 1'b0;
      data_wr      <= 1'b0;
    end else begin
      prog_error   <= next_perr;
      lock_error   <= next_lerr;
      unlock_pulse <= next_unlock;
      data_wr      <= next_dwr;
    end
  end

  // ----------------------------------------------------------------
  // Program data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_word <= 16'h0000;
    end else if (next_dwr) begin
      data_word <= cmd_data;
    end
  end

  // ----------------------------------------------------------------
  // Factory block address
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fx_block <= '0;
    end else if (fx_capture) begin
      fx_block <= cmd_block;
    end
  end

  // ----------------------------------------------------------------
  // Word counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : fesc_seq

/* File: verif/fesc_seq_chk.sv */
// Port assertions for the sequencer
`timescale 1ns/1ps
module fesc_seq_chk
  import fesc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        cmd_wr,
  input wire logic [15:0] cmd_data,
  input wire logic        op_done,
  input wire logic [3:0]  state_code,
  input wire logic        prog_error,
  input wire logic        lock_error,
  input wire logic        unlock_pulse,
  input wire logic        data_wr,
  input wire logic [15:0] data_word
);
  wire logic [7:0] c = cmd_data[7:0];
  wire logic       w = cmd_wr && !op_done;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_wp_suspend: assert property (state_code == 4'h3 && w |=> state_code == ($past(c) == 8'hB0 ? 4'h4 : 4'h3))
    else $error("word program suspend wrong");
  a_wp_resume: assert property (state_code == 4'h4 && w |=> state_code == ($past(c) == 8'hD0 ? 4'h3 : 4'h4))
    else $error("word program resume wrong");
  a_bp_confirm: assert property (state_code == 4'h7 && cmd_wr |=>
    ($past(c) == 8'hD0 ? state_code == 4'h8 && !prog_error : state_code == 4'h1 && prog_error))
    else $error("buffered confirm wrong");
  a_bp_suspend: assert property (state_code == 4'h8 && w |=> state_code == ($past(c) == 8'hB0 ? 4'h9 : 4'h8))
    else $error("buffered suspend wrong");
  a_fx_setup: assert property (state_code == 4'hB && cmd_wr |=>
    ($past(c) == 8'hD0 ? state_code == 4'hC : state_code == 4'h0 && prog_error))
    else $error("factory setup wrong");
  a_fx_data: assert property (state_code == 4'hD && w |=>
    (state_code == 4'hD ? data_wr && data_word == $past(cmd_data) : state_code == 4'h0 && !data_wr))
    else $error("factory data wrong");
  a_lock_setup: assert property (state_code == 4'hA && cmd_wr |=>
    state_code == 4'h1 && unlock_pulse == ($past(c) == 8'hD0) && lock_error != unlock_pulse)
    else $error("lock setup wrong");
endmodule : fesc_seq_chk
bind fesc_seq fesc_seq_chk i_fesc_seq_chk (.*);

/* File: verif/fesc_host.sv */
// Host controller model issuing command writes
`timescale 1ns/1ps
module fesc_host (
  input  wire logic ref_clk,
  output logic        cmd_wr = 1'b0,
  output logic [15:0] cmd_data = 16'h0000,
  output logic [9:0]  cmd_block = 10'h000
);
  task automatic put(input logic [15:0] d, input logic [9:0] b);
    @(posedge ref_clk) #2;
    {cmd_wr, cmd_data, cmd_block} = {1'b1, d, b};
    @(posedge ref_clk) #2;
    {cmd_wr, cmd_data, cmd_block} = {1'b0, ~d, ~b};
  endtask : put
endmodule : fesc_host

/* File: verif/fesc_seq_test.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module fesc_seq_test import fesc_pkg::*; ;
  logic ref_clk, rst_n, cmd_wr, ees, efx, op_done, prog_error, lock_error, unlock_pulse, data_wr;
  logic [15:0] cmd_data, data_word;
  logic [9:0]  cmd_block, blk = 10'h2A5;
  logic [3:0]  state_code, st;
  logic [7:0]  c;
  int          fails = 0, check_count = 0, seed = 7707, cyc = 0;
  fesc_host i_fesc_host (.ref_clk(ref_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data), .cmd_block(cmd_block));
  fesc_seq i_fesc_seq (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .cmd_block(cmd_block), .enter_erase_susp(ees), .enter_factory(efx), .op_done(op_done),
    .state_code(state_code), .prog_error(prog_error), .lock_error(lock_error),
    .unlock_pulse(unlock_pulse), .data_wr(data_wr), .data_word(data_word));
  function automatic logic [3:0] nxt(input logic [3:0] s, input logic [7:0] k);
    return (s == 4'h3) ? ((k == 8'hB0) ? 4'h4 : 4'h3) : ((k == 8'hD0) ? 4'h3 : 4'h4);
  endfunction : nxt
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic pin(input logic [2:0] v);
    @(posedge ref_clk) #2;
    {ees, efx, op_done} = v;
    @(posedge ref_clk) #2;
    {ees, efx, op_done} = 3'b000;
  endtask : pin
  task automatic w(input logic [15:0] d);
    i_fesc_host.put(d, blk);
  endtask : w
  task automatic rc();
    c = 8'($random(seed));
    if (c == 8'hD0) c = 8'h00;
  endtask : rc
  task automatic fill();
    w(16'h00E8);
    w(16'h001F);
    repeat (32) w(16'($random(seed)));
    chk("state", 16'(state_code), 16'h0007);
  endtask : fill
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    {rst_n, ees, efx, op_done} = 4'h0;
    repeat (2) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    pin(3'b100);
    w(16'h0010);
    w(16'h1234);
    st = 4'h3;
    for (int i = 0; i < 12; i++) begin
      rc();
      if (i % 3 == 0) c = (st == 4'h3) ? 8'hB0 : 8'hD0;
      w({8'h00, c});
      st = nxt(st, c);
      chk("state", 16'(state_code), 16'(st));
    end
    if (st == 4'h4) w(16'h00D0);
    pin(3'b001);
    $display("word program test done");
    fill();
    rc();
    w({8'h00, c});
    chk("prog_error", 16'(prog_error), 16'h0001);
    fill();
    w(16'h00D0);
    w(16'h0070);
    chk("state", 16'(state_code), 16'h0008);
    w(16'h00B0);
    chk("state", 16'(state_code), 16'h0009);
    w(16'h00D0);
    pin(3'b001);
    w(16'h0060);
    w(16'h00D0);
    chk("unlock_pulse", 16'(unlock_pulse), 16'h0001);
    w(16'h0060);
    w({8'h00, c});
    chk("lock_error", 16'(lock_error), 16'h0001);
    $display("suspend test done");
    w(16'h00D0);
    pin(3'b010);
    w({8'h00, c});
    chk("prog_error", 16'(prog_error), 16'h0001);
    pin(3'b010);
    w(16'h00D0);
    repeat (31) w(16'($random(seed)));
    chk("state", 16'(state_code), 16'h000C);
    w(16'h5A5A);
    chk("state", 16'(state_code), 16'h000D);
    w(16'h00B0);
    chk("data_word", data_word, 16'h00B0);
    blk = blk ^ 10'h001;
    w(16'h00B0);
    chk("state", 16'(state_code), 16'h0000);
    $display("factory test done");
    complete_run();
  end
endmodule : fesc_seq_test
